/* File: design/dsli_core.sv */
/*
 contents: serial write, readback and update logic of the converter interface
 assumes: mclk_in much faster than the link clock; all pins are asynchronous
*/
`timescale 1ns/1ps

// Notes on behaviour
// - shift only while frame select is low
// - 24-bit register samples input on falling edges
// - serial output changes on rising clock edges
// - load tied low: update at frame end
// - load high: defer update to load fall
// - clear loads preset code, coding selects level
// - reset restores power-on state
// - frame select falling starts, rising ends frame
module dsli_core #(
   parameter logic [19:0] CLEAR_CODE = dsli_pkg::CLEAR_CODE_DEFAULT
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic frame_sel_n_in,
   input wire logic sclk_in,
   input wire logic serial_in,
   input wire logic load_output_n_in,
   input wire logic clear_to_preset_n_in,
   input wire logic device_reset_n_in,
   input wire logic twos_comp_in,
   output logic serial_out,
   output logic [19:0] dac_code_out,
   output logic [19:0] input_reg_out,
   output logic [23:0] last_word_out,
   output logic output_update_out
);
   // two-stage synchronisers for the six pins, packed
   logic [5:0] sync_a;
   logic [5:0] sync_b;
   logic [5:0] prev;
   // synchronised levels
   logic fs_n, sck, sdi, ld_n, clear_n, dev_rst_n;
   assign fs_n = sync_b[0];
   assign sck = sync_b[1];
   assign sdi = sync_b[2];
   assign ld_n = sync_b[3];
   assign clear_n = sync_b[4];
   assign dev_rst_n = sync_b[5];
   // edge strobes, one mclk cycle each
   logic fs_fall, fs_rise, sck_fall, sck_rise, ld_fall;
   assign fs_fall = prev[0] & ~fs_n;
   assign fs_rise = ~prev[0] & fs_n;
   assign sck_fall = prev[1] & ~sck;
   assign sck_rise = ~prev[1] & sck;
   assign ld_fall = prev[3] & ~ld_n;
   // frame state and shift machinery
   dsli_pkg::dsli_state_t state;
   logic [23:0] shift;
   logic [4:0] count;
   logic pending;
   // soft reset from the device reset pin, acts like power-on
   logic soft_rst;
   assign soft_rst = ~dev_rst_n;

   // synchroniser chain; first stage only feeds second
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync_a <= 6'h3b;
         sync_b <= 6'h3b;
         prev <= 6'h3b;
      end
      else
      begin
         sync_a <= {device_reset_n_in, clear_to_preset_n_in, load_output_n_in,
                    serial_in, sclk_in, frame_sel_n_in};
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   // frame tracking: falling select opens, rising select closes
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         state <= dsli_pkg::DSLI_IDLE;
      else if (soft_rst)
         state <= dsli_pkg::DSLI_IDLE;
      else
      begin
         case (state)
            dsli_pkg::DSLI_IDLE:
               if (fs_fall)
                  state <= dsli_pkg::DSLI_SHIFT;
            dsli_pkg::DSLI_SHIFT:
               if (fs_rise)
                  state <= dsli_pkg::DSLI_IDLE;
            default:
               state <= dsli_pkg::DSLI_IDLE;
         endcase
      end
   end

   // shift register samples the input on falling link clock edges in a frame
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         shift <= 24'h000000;
         count <= 5'h00;
      end
      else if (soft_rst)
      begin
         shift <= 24'h000000;
         count <= 5'h00;
      end
      else if (fs_fall)
         count <= 5'h00;
      else if (state == dsli_pkg::DSLI_SHIFT && !fs_n && sck_fall)
      begin
         shift <= {shift[22:0], sdi};
         // saturate so overlong frames cannot wrap the count
         if (count != 5'(dsli_pkg::WORD_BITS))
            count <= count + 5'h01;
      end
   end

   // readback: msb of the shift register leaves on rising edges
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         serial_out <= 1'b0;
      else if (soft_rst)
         serial_out <= 1'b0;
      else if (state == dsli_pkg::DSLI_SHIFT && sck_rise)
         serial_out <= shift[23];
   end

   // a full word is only accepted at frame end with at least 24 bits, the count saturating at 24
   logic word_done;
   assign word_done = (state == dsli_pkg::DSLI_SHIFT) && fs_rise
                      && (count == 5'(dsli_pkg::WORD_BITS));

   // input register, converter register and deferred update
   logic [19:0] clear_level;
   assign clear_level = twos_comp_in ? (CLEAR_CODE ^ dsli_pkg::CODE_MSB) : CLEAR_CODE;
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         input_reg_out <= dsli_pkg::CODE_RESET;
         dac_code_out <= dsli_pkg::CODE_RESET;
         last_word_out <= 24'h000000;
         pending <= 1'b0;
         output_update_out <= 1'b0;
      end
      else if (soft_rst)
      begin
         input_reg_out <= dsli_pkg::CODE_RESET;
         dac_code_out <= dsli_pkg::CODE_RESET;
         last_word_out <= 24'h000000;
         pending <= 1'b0;
         output_update_out <= 1'b0;
      end
      else
      begin
         output_update_out <= 1'b0;
         if (!clear_n)
         begin
            // clear outranks any load in the same cycle
            dac_code_out <= clear_level;
            output_update_out <= 1'b1;
         end
         else if (word_done && !ld_n)
         begin
            input_reg_out <= shift[19:0];
            dac_code_out <= shift[19:0];
            output_update_out <= 1'b1;
            pending <= 1'b0;
         end
         else if (ld_fall && pending)
         begin
            dac_code_out <= input_reg_out;
            output_update_out <= 1'b1;
            pending <= 1'b0;
         end
         if (word_done)
            last_word_out <= shift;
         if (word_done && ld_n)
         begin
            input_reg_out <= shift[19:0];
            pending <= 1'b1;
         end
      end
   end

   // checks
   property p_shift_in_frame;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state == dsli_pkg::DSLI_IDLE && !soft_rst) |=> $stable(shift) || $past(fs_fall);
   endproperty
   a_shift_in_frame: assert property (p_shift_in_frame) else $error("shift moved outside frame");

   property p_shift_bit;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (state == dsli_pkg::DSLI_SHIFT && !fs_n && sck_fall && !soft_rst && !fs_fall)
      |=> shift[0] == $past(sdi);
   endproperty
   a_shift_bit: assert property (p_shift_bit) else $error("input bit not captured");

   property p_sdo_rise;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (!sck_rise && !soft_rst) |=> $stable(serial_out);
   endproperty
   a_sdo_rise: assert property (p_sdo_rise) else $error("serial out moved off rising edge");

   property p_load_low;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (word_done && !ld_n && clear_n && !soft_rst) |=> dac_code_out == $past(shift[19:0]);
   endproperty
   a_load_low: assert property (p_load_low) else $error("no update at frame end");

   property p_defer;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (word_done && ld_n && clear_n && !soft_rst) |=> $stable(dac_code_out) && pending;
   endproperty
   a_defer: assert property (p_defer) else $error("deferred update leaked");

   property p_clear;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (!clear_n && !soft_rst) |=> dac_code_out == $past(clear_level) && output_update_out;
   endproperty
   a_clear: assert property (p_clear) else $error("clear code not loaded");

   property p_soft_reset;
      @(posedge mclk_in) disable iff (!rst_n_in)
      soft_rst |=> dac_code_out == dsli_pkg::CODE_RESET && !pending
                   && state == dsli_pkg::DSLI_IDLE;
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("reset state wrong");

   property p_frame;
      @(posedge mclk_in) disable iff (!rst_n_in)
      (fs_rise && !soft_rst) |=> state == dsli_pkg::DSLI_IDLE;
   endproperty
   a_frame: assert property (p_frame) else $error("frame not closed");

   c_direct: cover property (@(posedge mclk_in) disable iff (!rst_n_in) word_done && !ld_n);
   c_defer: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      ld_fall && pending && clear_n);
   c_clear: cover property (@(posedge mclk_in) disable iff (!rst_n_in) !clear_n);
endmodule : dsli_core

/* File: include/dsli_pkg.sv */
/*
 contents: shared constants for the dac serial load interface
 assumes: included before design/dsli_core.sv
*/
package dsli_pkg;
   // width of the serial input shift register
   localparam int unsigned WORD_BITS = 24;
   // width of the converter code held in the registers
   localparam int unsigned CODE_BITS = 20;
   // width of the bit counter, enough to count to WORD_BITS
   localparam int unsigned CNT_BITS = 5;
   // power-on contents of input and converter registers
   localparam logic [19:0] CODE_RESET = 20'h00000;
   // default preset code that the clear input forces
   localparam logic [19:0] CLEAR_CODE_DEFAULT = 20'h00000;
   // offset that turns a twos complement code into straight binary
   localparam logic [19:0] CODE_MSB = 20'h80000;
   // link clock limit set by the host, kept for reference, MHz
   localparam int unsigned LINK_MAX_MHZ = 35;
   // frame states
   typedef enum logic [0:0] {
      DSLI_IDLE = 1'b0,
      DSLI_SHIFT = 1'b1
   } dsli_state_t;
endpackage : dsli_pkg

/* File: tb/dsli_host.sv */
/*
 contents: behavioural host that frames words onto the serial load pins
 assumes: driven from mclk falling edges; link clock of 8 mclk periods
*/
`timescale 1ns/1ps
module dsli_host (
   input wire logic mclk_in,
   input wire logic serial_out_in,
   output logic frame_sel_n_out,
   output logic sclk_out,
   output logic serial_in_out
);
   logic [23:0] readback; // bits seen on the device output, msb first
   // idle: select high, link clock parked high, no traffic
   initial
   begin
      frame_sel_n_out = 1'b1;
      sclk_out = 1'b1;
      serial_in_out = 1'b0;
      readback = 24'h000000;
   end
   // one frame msb first; sel_on low leaves the device unselected
   task automatic send(input logic [23:0] word, input int nbits, input logic sel_on);
      repeat (4) @(negedge mclk_in);
      frame_sel_n_out = ~sel_on;
      for (int i = 23; i > 23 - nbits; i--)
      begin
         serial_in_out = word[i];
         // 4 low plus 4 high mclk keeps the link well under its limit
         repeat (4) @(negedge mclk_in);
         readback = {readback[22:0], serial_out_in};
         sclk_out = 1'b0;
         repeat (4) @(negedge mclk_in);
         sclk_out = 1'b1;
      end
      repeat (4) @(negedge mclk_in);
      frame_sel_n_out = 1'b1;
      // released data line must not keep showing the last bit
      serial_in_out = ~serial_in_out;
      repeat (6) @(negedge mclk_in);
   endtask : send
endmodule : dsli_host

/* File: tb/tb_dsli_core.sv */
/*
 contents: self-checking bench for the converter serial load interface
 assumes: dsli_core and dsli_host compiled first; 25 MHz clock
*/
`timescale 1ns/1ps
module tb_dsli_core;
   localparam logic [19:0] PRESET = 20'h3a5c1; // nonzero clear code
   logic mclk_in, rst_n_in, load_n, clear_n, dev_rst_n, twos;
   logic frame_sel_n, sclk, sdi, serial_out, update;
   logic [19:0] dac_code, input_reg;
   logic [23:0] last_word;
   int num_errors = 0;
   int samples_checked = 0;
   int pulses = 0; // output update pulses seen
   dsli_core #(.CLEAR_CODE(PRESET)) DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .frame_sel_n_in(frame_sel_n), .sclk_in(sclk), .serial_in(sdi),
      .load_output_n_in(load_n), .clear_to_preset_n_in(clear_n),
      .device_reset_n_in(dev_rst_n), .twos_comp_in(twos), .serial_out(serial_out),
      .dac_code_out(dac_code), .input_reg_out(input_reg), .last_word_out(last_word),
      .output_update_out(update));
   dsli_host host (.mclk_in(mclk_in), .serial_out_in(serial_out), .frame_sel_n_out(frame_sel_n),
      .sclk_out(sclk), .serial_in_out(sdi));
   // 40 ns system clock
   initial
   begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) if (update === 1'b1) pulses++;
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge mclk_in);
   endtask : wait_cyc
   task automatic chk_all(input logic [19:0] d, input logic [19:0] r, input logic [23:0] w);
      check("dac_code", {4'h0, dac_code}, {4'h0, d});
      check("input_reg", {4'h0, input_reg}, {4'h0, r});
      check("last_word", last_word, w);
   endtask : chk_all
   // load tied low: whole word lands at frame end with one pulse
   task automatic t_load_low;
      pulses = 0;
      host.send(24'h5abcde, 24, 1'b1);
      chk_all(20'habcde, 20'habcde, 24'h5abcde);
      check("pulses", 24'(pulses), 24'h000001);
   endtask : t_load_low
   // load high during frame defers the output until load falls
   task automatic t_deferred;
      load_n = 1'b1;
      pulses = 0;
      host.send(24'ha13579, 24, 1'b1);
      check("readback", host.readback, 24'h5abcde);
      chk_all(20'habcde, 20'h13579, 24'ha13579);
      check("pulses", 24'(pulses), 24'h000000);
      load_n = 1'b0;
      wait_cyc(8);
      check("dac_code", {4'h0, dac_code}, 24'h013579);
      check("pulses", 24'(pulses), 24'h000001);
   endtask : t_deferred
   // short frame and unselected clocking leave the converter, input and last word registers alone
   task automatic t_ignored;
      host.send(24'h0fffff, 23, 1'b1);
      chk_all(20'h13579, 20'h13579, 24'ha13579);
      host.send(24'h0fffff, 24, 1'b0);
      chk_all(20'h13579, 20'h13579, 24'ha13579);
      // stray clocking while unselected would have overwritten the short frame's bits
      host.send(24'h2468ac, 24, 1'b1);
      check("readback", host.readback, 24'h87ffff);
      chk_all(20'h468ac, 20'h468ac, 24'h2468ac);
   endtask : t_ignored
   // clear forces the preset in both codings
   task automatic t_clear;
      clear_n = 1'b0;
      wait_cyc(6);
      check("dac_code", {4'h0, dac_code}, {4'h0, PRESET});
      check("update", {23'h000000, update}, 24'h000001);
      twos = 1'b1;
      wait_cyc(6);
      check("dac_code", {4'h0, dac_code}, {4'h0, PRESET ^ 20'h80000});
      clear_n = 1'b1;
      twos = 1'b0;
   endtask : t_clear
   // device reset pin returns the power-on state
   task automatic t_dev_reset;
      dev_rst_n = 1'b0;
      wait_cyc(6);
      chk_all(20'h00000, 20'h00000, 24'h000000);
      dev_rst_n = 1'b1;
      wait_cyc(6);
   endtask : t_dev_reset
   // main sequence, driven on falling edges
   initial
   begin
      {rst_n_in, load_n, clear_n, dev_rst_n, twos} = 5'b00110;
      wait_cyc(10);
      rst_n_in = 1'b1;
      wait_cyc(4);
      chk_all(20'h00000, 20'h00000, 24'h000000);
      t_load_low();
      t_deferred();
      t_ignored();
      t_clear();
      t_dev_reset();
      close_out();
   end
   // watchdog: the run needs about 43 us
   initial
   begin
      #200000;
      num_errors++;
      close_out();
   end
endmodule : tb_dsli_core
